// *** rtl/fsled_pattern.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------------
// one indicator pattern generator on the shared ms tick
// ------------------------------------------------------------------
module fsled_pattern (
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 msTick,
  input  wire fsled_pkg::fsled_pat_t pat,
  output logic                      led
);

  logic [fsled_pkg::MS_W-1:0] phase_reg;
  logic [fsled_pkg::MS_W-1:0] phase_next;
  fsled_pkg::fsled_pat_t      last_reg;
  logic                       led_next;
  logic [fsled_pkg::MS_W-1:0] period;
  logic                       patChange;

  assign patChange = (pat != last_reg);
  assign period =
    (pat == fsled_pkg::PAT_FLASH2) ? fsled_pkg::MS_W'(2 * fsled_pkg::FLASH2_HALF_MS) :
    (pat == fsled_pkg::PAT_BLINK)  ? fsled_pkg::MS_W'(2 * fsled_pkg::BLINK_HALF_MS) :
    (pat == fsled_pkg::PAT_SINGLE) ? fsled_pkg::MS_W'(fsled_pkg::SINGLE_LEN_MS) :
    fsled_pkg::MS_W'(fsled_pkg::DOUBLE_LEN_MS);
  assign phase_next = patChange ? '0 :
    !msTick ? phase_reg :
    (phase_reg == period - 1'b1) ? '0 : phase_reg + 1'b1;

  always_comb begin
    case (pat)
      fsled_pkg::PAT_ON:     led_next = 1'b1;
      fsled_pkg::PAT_FLASH2: led_next = phase_next < fsled_pkg::MS_W'(fsled_pkg::FLASH2_HALF_MS);
      fsled_pkg::PAT_BLINK:  led_next = phase_next < fsled_pkg::MS_W'(fsled_pkg::BLINK_HALF_MS);
      fsled_pkg::PAT_SINGLE: led_next = phase_next < fsled_pkg::MS_W'(fsled_pkg::BLINK_HALF_MS);
      fsled_pkg::PAT_DOUBLE: led_next =
        (phase_next < fsled_pkg::MS_W'(fsled_pkg::BLINK_HALF_MS)) ||
        ((phase_next >= fsled_pkg::MS_W'(2 * fsled_pkg::BLINK_HALF_MS)) &&
         (phase_next < fsled_pkg::MS_W'(3 * fsled_pkg::BLINK_HALF_MS)));
      default:               led_next = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= '0;
      last_reg  <= fsled_pkg::PAT_OFF;
      led       <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      last_reg  <= pat;
      led       <= led_next;
    end
  end

endmodule : fsled_pattern

// *** rtl/fsled_pkg.sv ***
package fsled_pkg;

  // ----------------------------------------------------------------
  // clock and timebase
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned CLK_PER_MS    = CLK_MHZ * 1000;
  localparam int unsigned TICK_W        = 18;

  // ----------------------------------------------------------------
  // pattern times in ms
  // ----------------------------------------------------------------
  localparam int unsigned FLASH1_HALF_MS = 500;
  localparam int unsigned FLASH1_LEN_MS  = 3000;
  localparam int unsigned FLASH2_HALF_MS = 250;
  localparam int unsigned BLINK_HALF_MS  = 200;
  localparam int unsigned LONG_OFF_MS    = 1000;
  localparam int unsigned FLICK_HALF_MS  = 50;
  localparam int unsigned SINGLE_LEN_MS  = BLINK_HALF_MS + LONG_OFF_MS;
  localparam int unsigned DOUBLE_LEN_MS  = 3 * BLINK_HALF_MS + LONG_OFF_MS;
  localparam int unsigned MS_W           = 12;

  // ----------------------------------------------------------------
  // wishbone register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_IOSTAT = 8'h04;
  localparam logic [7:0] ADDR_SLSTAT = 8'h08;
  localparam logic [7:0] ADDR_LEDS   = 8'h0C;

  // control register fields
  localparam int unsigned CTRL_SEL_BIT   = 0;
  localparam int unsigned CTRL_IDENT_BIT = 1;

  // io-device status fields
  localparam int unsigned IO_WDOG_BIT   = 0;
  localparam int unsigned IO_DIAG_BIT   = 1;
  localparam int unsigned IO_SYSERR_BIT = 2;
  localparam int unsigned IO_NODX_BIT   = 3;
  localparam int unsigned IO_NOCFG_BIT  = 4;
  localparam int unsigned IO_LOWSPD_BIT = 5;
  localparam int unsigned IO_NOLINK_BIT = 6;
  localparam int unsigned IO_W          = 7;

  // slave status fields
  localparam int unsigned SL_STATE_LSB  = 0;
  localparam int unsigned SL_STATE_W    = 2;
  localparam int unsigned SL_CFGERR_BIT = 2;
  localparam int unsigned SL_LOCERR_BIT = 3;
  localparam int unsigned SL_APPWD_BIT  = 4;
  localparam int unsigned SL_W          = 5;

  localparam logic [1:0] SL_INIT   = 2'h0;
  localparam logic [1:0] SL_PREOP  = 2'h1;
  localparam logic [1:0] SL_SAFEOP = 2'h2;
  localparam logic [1:0] SL_OP     = 2'h3;

  localparam logic [1:0]  CTRL_RESET   = 2'h0;
  localparam logic [6:0]  IOSTAT_RESET = 7'h00;
  localparam logic [4:0]  SLSTAT_RESET = 5'h00;

  typedef enum logic [5:0] {
    PAT_OFF    = 6'h01,
    PAT_ON     = 6'h02,
    PAT_FLASH2 = 6'h04,
    PAT_BLINK  = 6'h08,
    PAT_SINGLE = 6'h10,
    PAT_DOUBLE = 6'h20
  } fsled_pat_t;

endpackage : fsled_pkg

// *** rtl/fsled_top.sv ***
`timescale 1ns/1ps
// Behaviour
// - io mode: ident request flashes system-failure red 1 Hz for 3 s.
// - io mode: watchdog, diagnosis or system error light system-failure steady red.
// - io mode: no data exchange flashes bus-failure red 250/250 ms.
// - io mode: no config, low speed or no link light bus-failure red.
// - io mode: green port light follows port link.
// - io mode: yellow port light flickers on frame traffic, else dark.
// - 1 Hz flash is 500/500 ms and stops after 3 s.
// - heavy traffic flicker toggles 50 ms on, 50 ms off.
// - light traffic flicker follows individual frame events.
// - slave mode: run light dark in init state.
// - slave mode: run light blinks green 2.5 Hz in pre-operational.
// - slave mode: run light single-flashes green in safe-operational.
// - slave mode: run light steady green in operational.
// - slave mode: error light dark with no error.
// - slave mode: configuration error blinks error red 2.5 Hz.
// - slave mode: local state change single-flashes error red.
// - slave mode: application watchdog double-flashes error red.
// - slave mode: linked idle port shows steady green.
// - slave mode: linked busy port flickers green; unlinked dark.
// - slave mode: yellow port lights held dark.
// - 2.5 Hz blink is 200 ms on, 200 ms off.
// - single flash is 200 ms on then 1000 ms off.
// - double flash is two 200 ms pulses, 200 ms gap, 1000 ms off.
module fsled_top (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        portZeroLink,
  input  wire logic        portOneLink,
  input  wire logic        portZeroFrame,
  input  wire logic        portOneFrame,
  output logic             sysFailRed,
  output logic             runGreen,
  output logic             busFailRed,
  output logic             portZeroGreen,
  output logic             portOneGreen,
  output logic             portZeroYellow,
  output logic             portOneYellow
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pinMeta_reg;
  logic [3:0] pinSync_reg;
  logic [3:0] pinPrev_reg;
  logic [1:0] linkSync;
  logic [1:0] frameEvt;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta_reg <= 4'h0;
      pinSync_reg <= 4'h0;
      pinPrev_reg <= 4'h0;
    end else begin
      pinMeta_reg <= {portOneFrame, portZeroFrame, portOneLink, portZeroLink};
      pinSync_reg <= pinMeta_reg;
      pinPrev_reg <= pinSync_reg;
    end
  end

  assign linkSync = pinSync_reg[1:0];
  assign frameEvt = pinSync_reg[3:2] & ~pinPrev_reg[3:2];

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [1:0]                 ctrl_reg;
  logic [fsled_pkg::IO_W-1:0] ioStat_reg;
  logic [fsled_pkg::SL_W-1:0] slStat_reg;
  logic                       wbReq;
  logic                       wbWr;
  logic                       hitCtrl;
  logic                       hitIo;
  logic                       hitSl;
  logic                       hitLeds;
  logic [31:0]                rdData;
  logic                       identStart;
  logic                       identActive;

  assign wbReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWr    = wbReq & wb_we_i & wb_sel_i[0];
  assign hitCtrl = (wb_adr_i == fsled_pkg::ADDR_CTRL);
  assign hitIo   = (wb_adr_i == fsled_pkg::ADDR_IOSTAT);
  assign hitSl   = (wb_adr_i == fsled_pkg::ADDR_SLSTAT);
  assign hitLeds = (wb_adr_i == fsled_pkg::ADDR_LEDS);
  assign identStart = wbWr & hitCtrl & wb_dat_i[fsled_pkg::CTRL_IDENT_BIT];

  assign rdData =
    hitCtrl ? {30'h0, identActive, ctrl_reg[fsled_pkg::CTRL_SEL_BIT]} :
    hitIo   ? {25'h0, ioStat_reg} :
    hitSl   ? {27'h0, slStat_reg} :
    hitLeds ? {25'h0, portOneYellow, portZeroYellow, portOneGreen, portZeroGreen,
               busFailRed, runGreen, sysFailRed} :
    32'h0;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg   <= fsled_pkg::CTRL_RESET;
      ioStat_reg <= fsled_pkg::IOSTAT_RESET;
      slStat_reg <= fsled_pkg::SLSTAT_RESET;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= wbReq ? rdData : 32'h0;
      if (wbWr && hitCtrl) ctrl_reg <= {1'b0, wb_dat_i[fsled_pkg::CTRL_SEL_BIT]};
      if (wbWr && hitIo) ioStat_reg <= wb_dat_i[fsled_pkg::IO_W-1:0];
      if (wbWr && hitSl) slStat_reg <= wb_dat_i[fsled_pkg::SL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // millisecond timebase
  // ----------------------------------------------------------------
  logic [fsled_pkg::TICK_W-1:0] div_reg;
  logic                         msTick;

  assign msTick = (div_reg == fsled_pkg::TICK_W'(fsled_pkg::CLK_PER_MS - 1));

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) div_reg <= '0;
    else div_reg <= msTick ? '0 : div_reg + 1'b1;
  end

  // ----------------------------------------------------------------
  // timed identification flash
  // ----------------------------------------------------------------
  logic [fsled_pkg::MS_W-1:0] identMs_reg;
  logic                       identOn;

  assign identActive = (identMs_reg != '0);
  assign identOn = identActive &&
    (((fsled_pkg::MS_W'(fsled_pkg::FLASH1_LEN_MS) - identMs_reg) /
      fsled_pkg::MS_W'(fsled_pkg::FLASH1_HALF_MS)) % 2 == 0);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) identMs_reg <= '0;
    else if (identStart) identMs_reg <= fsled_pkg::MS_W'(fsled_pkg::FLASH1_LEN_MS);
    else if (msTick && identActive) identMs_reg <= identMs_reg - 1'b1;
  end

  // ----------------------------------------------------------------
  // per-port flicker
  // ----------------------------------------------------------------
  logic [1:0]                 flick_reg;
  logic [1:0]                 busy_reg;
  logic [fsled_pkg::MS_W-1:0] flickMs_reg [2];

  for (genvar p = 0; p < 2; p++) begin : g_flick
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        flick_reg[p]   <= 1'b0;
        busy_reg[p]    <= 1'b0;
        flickMs_reg[p] <= '0;
      end else if (frameEvt[p] && !busy_reg[p]) begin
        flick_reg[p]   <= 1'b1;
        busy_reg[p]    <= 1'b1;
        flickMs_reg[p] <= '0;
      end else if (busy_reg[p] && msTick) begin
        if (flickMs_reg[p] == fsled_pkg::MS_W'(fsled_pkg::FLICK_HALF_MS - 1)) begin
          flickMs_reg[p] <= '0;
          flick_reg[p]   <= ~flick_reg[p];
          busy_reg[p]    <= flick_reg[p];
        end else begin
          flickMs_reg[p] <= flickMs_reg[p] + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pattern selection
  // ----------------------------------------------------------------
  logic                  slaveSel;
  logic [1:0]            slState;
  fsled_pkg::fsled_pat_t sysPat;
  fsled_pkg::fsled_pat_t busPat;
  fsled_pkg::fsled_pat_t runPat;
  fsled_pkg::fsled_pat_t errPat;
  fsled_pkg::fsled_pat_t redPat;
  fsled_pkg::fsled_pat_t busSel;
  logic                  sysPatLed;
  logic                  runPatLed;
  logic                  busPatLed;

  assign slaveSel = ctrl_reg[fsled_pkg::CTRL_SEL_BIT];
  assign slState  = slStat_reg[fsled_pkg::SL_STATE_LSB +: fsled_pkg::SL_STATE_W];

  assign sysPat = (ioStat_reg[fsled_pkg::IO_WDOG_BIT] || ioStat_reg[fsled_pkg::IO_DIAG_BIT] ||
                   ioStat_reg[fsled_pkg::IO_SYSERR_BIT]) ? fsled_pkg::PAT_ON :
                  fsled_pkg::PAT_OFF;
  assign busPat = (ioStat_reg[fsled_pkg::IO_NOCFG_BIT] || ioStat_reg[fsled_pkg::IO_LOWSPD_BIT] ||
                   ioStat_reg[fsled_pkg::IO_NOLINK_BIT]) ? fsled_pkg::PAT_ON :
                  ioStat_reg[fsled_pkg::IO_NODX_BIT] ? fsled_pkg::PAT_FLASH2 :
                  fsled_pkg::PAT_OFF;
  assign runPat = (slState == fsled_pkg::SL_OP)     ? fsled_pkg::PAT_ON :
                  (slState == fsled_pkg::SL_SAFEOP) ? fsled_pkg::PAT_SINGLE :
                  (slState == fsled_pkg::SL_PREOP)  ? fsled_pkg::PAT_BLINK :
                  fsled_pkg::PAT_OFF;
  assign errPat = slStat_reg[fsled_pkg::SL_APPWD_BIT]  ? fsled_pkg::PAT_DOUBLE :
                  slStat_reg[fsled_pkg::SL_LOCERR_BIT] ? fsled_pkg::PAT_SINGLE :
                  slStat_reg[fsled_pkg::SL_CFGERR_BIT] ? fsled_pkg::PAT_BLINK :
                  fsled_pkg::PAT_OFF;
  assign redPat = slaveSel ? fsled_pkg::PAT_OFF : sysPat;
  assign busSel = slaveSel ? errPat : busPat;

  fsled_pattern u_sys (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .msTick  (msTick),
    .pat     (redPat),
    .led     (sysPatLed)
  );

  fsled_pattern u_run (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .msTick  (msTick),
    .pat     (slaveSel ? runPat : fsled_pkg::PAT_OFF),
    .led     (runPatLed)
  );

  fsled_pattern u_bus (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .msTick  (msTick),
    .pat     (busSel),
    .led     (busPatLed)
  );

  // ----------------------------------------------------------------
  // led outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sysFailRed     <= 1'b0;
      runGreen       <= 1'b0;
      busFailRed     <= 1'b0;
      portZeroGreen  <= 1'b0;
      portOneGreen   <= 1'b0;
      portZeroYellow <= 1'b0;
      portOneYellow  <= 1'b0;
    end else begin
      sysFailRed <= slaveSel ? 1'b0 :
                    sysPatLed ? 1'b1 : identOn;
      runGreen   <= runPatLed;
      busFailRed <= busPatLed;
      if (slaveSel) begin
        portZeroGreen  <= linkSync[0] & (busy_reg[0] ? flick_reg[0] : 1'b1);
        portOneGreen   <= linkSync[1] & (busy_reg[1] ? flick_reg[1] : 1'b1);
        portZeroYellow <= 1'b0;
        portOneYellow  <= 1'b0;
      end else begin
        portZeroGreen  <= linkSync[0];
        portOneGreen   <= linkSync[1];
        portZeroYellow <= busy_reg[0] & flick_reg[0];
        portOneYellow  <= busy_reg[1] & flick_reg[1];
      end
    end
  end

endmodule : fsled_top

// *** sim/fieldbus_status_led_driver_tb.sv ***
`timescale 1ns/1ps
module fieldbus_status_led_driver_tb;
  logic        sys_clk;
  logic        resetn;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatW;
  logic [31:0] wbDatR;
  logic        wbAck;
  logic        p0Link, p1Link, p0Frame, p1Frame;
  logic [6:0]  ledVec;
  logic [31:0] rd;
  int          nFail;
  int          compares;
  int          i;

  fsled_top dut (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck), .portZeroLink(p0Link), .portOneLink(p1Link), .portZeroFrame(p0Frame),
    .portOneFrame(p1Frame), .sysFailRed(ledVec[0]), .runGreen(ledVec[1]),
    .busFailRed(ledVec[2]), .portZeroGreen(ledVec[3]), .portOneGreen(ledVec[4]),
    .portZeroYellow(ledVec[5]), .portOneYellow(ledVec[6]));
  fsled_phy_model phy0 (.sys_clk(sys_clk), .link(p0Link), .frame(p0Frame));
  fsled_phy_model phy1 (.sys_clk(sys_clk), .link(p1Link), .frame(p1Frame));

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      nFail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [31:0] q);
    @(posedge sys_clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= w;
    wbAdr  <= a;
    wbSel  <= s;
    wbDatW <= d;
    do @(posedge sys_clk); while (wbAck !== 1'b1);
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask : wb_cycle

  task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
    wb_cycle(1'b1, a, d, 4'hF, rd);
  endtask : wb_wr

  task automatic wb_rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb_cycle(1'b0, a, 32'h0, 4'hF, rd);
    chk_reg(rd, exp);
  endtask : wb_rd_chk

  // settle, then pins and indicator register
  task automatic chk_led(input logic [6:0] exp);
    repeat (8) @(posedge sys_clk);
    compares++;
    if (ledVec !== exp) begin
      nFail++;
      $display("BAD %0t got %h exp %h", $time, ledVec, exp);
    end
    wb_rd_chk(fsled_pkg::ADDR_LEDS, {25'h0, exp});
  endtask : chk_led

  task automatic give_verdict();
    $display("counts: %0d compares, %0d mismatches", compares, nFail);
    if (nFail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    nFail++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatW = 32'h0;
    nFail = 0;
    compares = 0;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    for (i = 0; i < 5; i++) wb_rd_chk(8'(4 * i), 32'h0);
    chk_led(7'h00);
    $display("test reset done");
    for (i = 0; i < 7; i++) begin
      wb_wr(fsled_pkg::ADDR_IOSTAT, 32'h1 << i);
      chk_led((i < 3) ? 7'h01 : 7'h04);
    end
    wb_wr(fsled_pkg::ADDR_IOSTAT, 32'h0);
    wb_cycle(1'b1, fsled_pkg::ADDR_IOSTAT, 32'h7F, 4'hE, rd);
    wb_rd_chk(fsled_pkg::ADDR_IOSTAT, 32'h0);
    wb_wr(fsled_pkg::ADDR_IOSTAT, 32'h5D);
    wb_rd_chk(fsled_pkg::ADDR_IOSTAT, 32'h5D);
    chk_led(7'h05);
    wb_wr(fsled_pkg::ADDR_IOSTAT, 32'h0);
    $display("test io status done");
    wb_wr(fsled_pkg::ADDR_CTRL, 32'h2);
    wb_rd_chk(fsled_pkg::ADDR_CTRL, 32'h2);
    chk_led(7'h01);
    phy0.set_link(1'b1);
    chk_led(7'h09);
    phy1.send_frame();
    chk_led(7'h49);
    phy0.set_link(1'b0);
    chk_led(7'h41);
    $display("test io ports done");
    phy0.set_link(1'b1);
    wb_wr(fsled_pkg::ADDR_CTRL, 32'h1);
    for (i = 0; i < 4; i++) begin
      wb_wr(fsled_pkg::ADDR_SLSTAT, 32'(i));
      chk_led((i == 0) ? 7'h08 : 7'h0A);
    end
    for (i = 2; i < 5; i++) begin
      wb_wr(fsled_pkg::ADDR_SLSTAT, 32'h3 | (32'h1 << i));
      chk_led(7'h0E);
    end
    wb_wr(fsled_pkg::ADDR_SLSTAT, 32'h3);
    chk_led(7'h0A);
    phy1.send_frame();
    chk_led(7'h0A);
    phy1.set_link(1'b1);
    phy1.send_frame();
    chk_led(7'h1A);
    $display("test slave done");
    give_verdict();
  end
endmodule : fieldbus_status_led_driver_tb

// *** sim/fsled_phy_model.sv ***
`timescale 1ns/1ps
module fsled_phy_model (
  input wire logic sys_clk,
  output logic     link,
  output logic     frame
);
  initial begin
    link = 1'b0;
    frame = 1'b0;
  end

  task automatic set_link(input logic up);
    @(posedge sys_clk);
    link <= up;
  endtask : set_link

  // one frame event, held past the input synchroniser
  task automatic send_frame();
    @(posedge sys_clk);
    frame <= 1'b1;
    repeat (4) @(posedge sys_clk);
    frame <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : send_frame
endmodule : fsled_phy_model

// *** sim/fsled_properties.sv ***
`timescale 1ns/1ps
module fsled_properties (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        portZeroLink,
  input wire logic        portOneLink,
  input wire logic        portZeroFrame,
  input wire logic        portOneFrame,
  input wire logic        sysFailRed,
  input wire logic        runGreen,
  input wire logic        busFailRed,
  input wire logic        portZeroGreen,
  input wire logic        portOneGreen,
  input wire logic        portZeroYellow,
  input wire logic        portOneYellow
);
  // ----------------------------------------------------------------
  // mode tracking
  // ----------------------------------------------------------------
  logic       modeReg;
  logic [3:0] ageReg;
  wire logic  reqNew = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic  ctrlWr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
                       && (wb_adr_i == fsled_pkg::ADDR_CTRL);
  wire logic  settled = (ageReg == 4'hF);
  wire logic  mapped = (wb_adr_i == fsled_pkg::ADDR_CTRL) || (wb_adr_i == fsled_pkg::ADDR_IOSTAT)
                       || (wb_adr_i == fsled_pkg::ADDR_SLSTAT) || (wb_adr_i == fsled_pkg::ADDR_LEDS);
  wire logic [6:0] ledVec = {portOneYellow, portZeroYellow, portOneGreen, portZeroGreen,
                             busFailRed, runGreen, sysFailRed};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      modeReg <= 1'b0;
      ageReg  <= 4'h0;
    end else if (ctrlWr) begin
      modeReg <= wb_dat_i[0];
      ageReg  <= 4'h0;
    end else if (!settled) begin
      ageReg  <= ageReg + 4'h1;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
  a_ack_after_req: assert property (reqNew |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_no_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_dat_zero_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_unmapped_zero: assert property (reqNew && !wb_we_i && !mapped |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_leds_mirror: assert property (reqNew && !wb_we_i && wb_adr_i == fsled_pkg::ADDR_LEDS
    |=> $stable(ledVec) |-> wb_dat_o[6:0] == ledVec)
    else $error("indicator register differs from pins");
  a_slave_yellow_dark: assert property (
    modeReg && settled |-> !portZeroYellow && !portOneYellow)
    else $error("yellow lit in slave mapping");
  a_io_run_dark: assert property (!modeReg && settled |-> !runGreen)
    else $error("run light lit in io mapping");
  a_slave_sys_dark: assert property (modeReg && settled |-> !sysFailRed)
    else $error("system light lit in slave mapping");
  a_io_link_green: assert property (
    (!modeReg && settled && $stable(portZeroLink)) [*8] |-> portZeroGreen == portZeroLink)
    else $error("green does not follow link");
  a_nolink_dark: assert property ((!portOneLink) [*8] |-> !portOneGreen)
    else $error("green lit without link");
endmodule : fsled_properties

bind fsled_top fsled_properties u_props (
  .sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .portZeroLink(portZeroLink),
  .portOneLink(portOneLink), .portZeroFrame(portZeroFrame), .portOneFrame(portOneFrame),
  .sysFailRed(sysFailRed), .runGreen(runGreen), .busFailRed(busFailRed),
  .portZeroGreen(portZeroGreen), .portOneGreen(portOneGreen),
  .portZeroYellow(portZeroYellow), .portOneYellow(portOneYellow));
